// File: sensorless_bldc_commutation_pwm.sv
// Purpose: Seven output timer channels, pattern evaluator, delay one-shot and period capture.
// Assumes: Period trigger and software strobes are on sys_clk_i; back voltage comparators are not.
// Notes: Outputs are registered; pin levels follow channel state one cycle later.
`timescale 1ns/1ps
module sensorless_bldc_commutation_pwm
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Group control of the output timer bank.
    input wire logic [6:0] channel_enable_i,
    input wire logic [6:0] output_enable_i,
    input wire logic global_trigger_i,
    input wire logic [6:0] pattern_mode_bit_i,
    input wire logic one_shot_bit_i,
    // Period trigger from the external period trigger channel.
    input wire logic period_trigger_i,
    // Shadow values of the PWM pair and of the delay channel.
    input wire bldc_comm_pkg::pwm_shadow_s ch0_shadow_i,
    input wire bldc_comm_pkg::pwm_shadow_s ch1_shadow_i,
    input wire bldc_comm_pkg::pwm_shadow_s ch2_shadow_i,
    // Pattern evaluator control.
    input wire logic evaluator_enable_i,
    input wire logic [1:0] update_trigger_select_i,
    input wire logic [13:0] next_pattern_control_i,
    input wire logic pattern_write_i,
    // Back voltage comparator inputs, phase inputs 3, 4 and 5.
    input wire logic [2:0] back_voltage_i,
    // Capture channel configuration.
    input wire logic pwm_measure_mode_i,
    input wire logic duty_level_select_i,
    input wire logic shadow_source_select_i,
    input wire logic capture_irq_enable_i,
    // Gate drives to the power stage.
    output logic [6:0] gate_drive_o,
    // Status towards software.
    output logic [13:0] output_pattern_control_o,
    output logic new_pattern_flag_o,
    output logic delay_trigger_o,
    output bldc_comm_pkg::capture_result_s capture_result_o,
    output logic capture_irq_o
);

    // Rate enables.
    logic [8:0] acc_ff; // Fractional accumulator for the fast timer rate.
    logic [7:0] slow_div_ff; // Counts fast ticks for the slow rate.
    logic [7:0] cap_div_ff; // Counts system cycles for the capture rate.
    logic fast_tick;
    logic slow_tick;
    logic cap_tick;
    logic [9:0] acc_sum;

    // Adding the fast rate each cycle and wrapping at the system rate gives an exact average.
    assign acc_sum = {1'b0, acc_ff} + {1'b0, bldc_comm_pkg::ACC_STEP};
    assign fast_tick = (acc_sum >= {1'b0, bldc_comm_pkg::ACC_WRAP});
    assign slow_tick = fast_tick && (slow_div_ff == bldc_comm_pkg::SLOW_LAST);
    assign cap_tick = (cap_div_ff == bldc_comm_pkg::CAP_LAST);

    // Divider state.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            acc_ff <= 9'h0;
            slow_div_ff <= 8'h0;
            cap_div_ff <= 8'h0;
        end
        else
        begin
            acc_ff <= fast_tick ? 9'(acc_sum - {1'b0, bldc_comm_pkg::ACC_WRAP}) : acc_sum[8:0];
            slow_div_ff <= fast_tick ? 8'(slow_div_ff + 8'h1) : slow_div_ff;
            cap_div_ff <= cap_tick ? 8'h0 : 8'(cap_div_ff + 8'h1);
        end
    end

    // Group start: enables and output enables take effect together on the global trigger.
    logic [6:0] run_ff;
    logic [6:0] outen_ff;

    // Staged enables are copied only on the trigger so all channels start on one edge.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            run_ff <= 7'h0;
            outen_ff <= 7'h0;
        end
        else if (global_trigger_i)
        begin
            run_ff <= channel_enable_i;
            outen_ff <= output_enable_i;
        end
    end

    // Complementary PWM pair.
    logic [15:0] cnt0_ff;
    logic [15:0] cnt1_ff;
    logic [15:0] cm0_0_ff;
    logic [15:0] cm1_0_ff;
    logic [15:0] cm0_1_ff;
    logic [15:0] cm1_1_ff;
    logic trig0;
    logic trig1;
    logic pwm_a;
    logic pwm_b;

    // Channel 0 passes the period trigger on, so channel 1 resets in the same cycle.
    assign trig0 = period_trigger_i && run_ff[0];
    assign trig1 = trig0 && run_ff[1];

    // Counter step: wraps at the fixed period when no trigger arrives in time.
    function automatic logic [15:0] step_cnt(input logic [15:0] c);
        step_cnt = (c >= 16'(bldc_comm_pkg::PWM_PERIOD - 16'h1)) ? 16'h0 : 16'(c + 16'h1);
    endfunction

    // Level rule: start level before the first edge and from the second edge on.
    function automatic logic pwm_level(input logic [15:0] c, input logic [15:0] cm0,
                                       input logic [15:0] cm1, input logic sl);
        pwm_level = ((c < cm1) || (c >= cm0)) ? sl : ~sl;
    endfunction

    assign pwm_a = pwm_level(cnt0_ff, cm0_0_ff, cm1_0_ff, bldc_comm_pkg::SL_CH0);
    assign pwm_b = pwm_level(cnt1_ff, cm0_1_ff, cm1_1_ff, bldc_comm_pkg::SL_CH1);

    // Channel 0 counter and compares; compares never change mid-period.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            cnt0_ff <= bldc_comm_pkg::CNT_RST;
            cm0_0_ff <= bldc_comm_pkg::PWM_PERIOD;
            cm1_0_ff <= bldc_comm_pkg::CNT_RST;
        end
        else if (trig0)
        begin
            cnt0_ff <= bldc_comm_pkg::CNT_RST;
            cm0_0_ff <= ch0_shadow_i.period_shadow;
            cm1_0_ff <= ch0_shadow_i.edge_shadow;
        end
        else if (fast_tick && run_ff[0])
        begin
            cnt0_ff <= step_cnt(cnt0_ff);
        end
    end

    // Channel 1 counter and compares, reset by the trigger handed on from channel 0.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            cnt1_ff <= bldc_comm_pkg::CNT_RST;
            cm0_1_ff <= bldc_comm_pkg::PWM_PERIOD;
            cm1_1_ff <= bldc_comm_pkg::CNT_RST;
        end
        else if (trig1)
        begin
            cnt1_ff <= bldc_comm_pkg::CNT_RST;
            cm0_1_ff <= ch1_shadow_i.period_shadow;
            cm1_1_ff <= ch1_shadow_i.edge_shadow;
        end
        else if (fast_tick && run_ff[1])
        begin
            cnt1_ff <= step_cnt(cnt1_ff);
        end
    end

    // Back voltage synchroniser and new pattern detection.
    logic [2:0] bv_meta_ff; // First stage, read only by the second.
    logic [2:0] bv_sync_ff;
    logic [2:0] bv_last_ff;
    logic new_pat;

    // A changed pattern counts only while the evaluator is enabled; software keeps it off at start.
    assign new_pat = evaluator_enable_i && (bv_sync_ff != bv_last_ff);

    // Two-stage synchroniser and previous-pattern store.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            bv_meta_ff <= 3'h0;
            bv_sync_ff <= 3'h0;
            bv_last_ff <= 3'h0;
        end
        else
        begin
            bv_meta_ff <= back_voltage_i;
            bv_sync_ff <= bv_meta_ff;
            bv_last_ff <= bv_sync_ff;
        end
    end

    // Delay one-shot channel on the slow clock.
    logic [15:0] cnt2_ff;
    logic [15:0] cm0_2_ff;
    logic [15:0] cm1_2_ff;
    logic busy2_ff;
    logic hit1;
    logic hit0;
    logic pwm_c;

    assign hit1 = busy2_ff && slow_tick && (cnt2_ff == cm1_2_ff);
    assign hit0 = busy2_ff && slow_tick && (cnt2_ff >= cm0_2_ff);
    assign pwm_c = busy2_ff ? ((cnt2_ff < cm1_2_ff) ? bldc_comm_pkg::SL_CH2 : ~bldc_comm_pkg::SL_CH2) : 1'b0;

    // A new pattern restarts the channel at zero for one period; one-shot stops it at the end.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            cnt2_ff <= bldc_comm_pkg::CNT_RST;
            cm0_2_ff <= bldc_comm_pkg::CNT_RST;
            cm1_2_ff <= bldc_comm_pkg::CNT_RST;
            busy2_ff <= 1'b0;
        end
        else if (new_pat && run_ff[2])
        begin
            cnt2_ff <= bldc_comm_pkg::CNT_RST;
            cm0_2_ff <= ch2_shadow_i.period_shadow;
            cm1_2_ff <= ch2_shadow_i.edge_shadow;
            busy2_ff <= 1'b1;
        end
        else if (hit0)
        begin
            cnt2_ff <= bldc_comm_pkg::CNT_RST;
            busy2_ff <= ~one_shot_bit_i;
        end
        else if (busy2_ff && slow_tick)
        begin
            cnt2_ff <= 16'(cnt2_ff + 16'h1);
        end
    end

    // Pattern evaluator output control.
    logic [13:0] pat_ff;
    logic pat_update;

    assign pat_update = (update_trigger_select_i == bldc_comm_pkg::TRIG_ON_DELAY) ? hit1 :
                        (update_trigger_select_i == bldc_comm_pkg::TRIG_ON_PATTERN) ? new_pat : 1'b0;

    // With the evaluator off software writes the pattern directly, as in open-loop start.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            pat_ff <= bldc_comm_pkg::PAT_RST;
        end
        else if ((evaluator_enable_i && pat_update) || (!evaluator_enable_i && pattern_write_i))
        begin
            pat_ff <= next_pattern_control_i;
        end
    end

    // Per-channel selection of evaluator output and final pin level.
    logic [6:0] own_pwm;
    logic [6:0] eval_out;
    logic [6:0] nxt_drive;

    // Channels 3 to 6 have no PWM of their own here; they serve only in pattern mode.
    assign own_pwm = {4'h0, pwm_c, pwm_b, pwm_a};

    function automatic logic pick(input logic [1:0] sel, input logic a, input logic b);
        case (sel)
            bldc_comm_pkg::SEL_ZERO: pick = 1'b0;
            bldc_comm_pkg::SEL_ONE: pick = 1'b1;
            bldc_comm_pkg::SEL_SRC_A: pick = a;
            default: pick = b;
        endcase
    endfunction

    for (genvar g = 0; g < 7; g++)
    begin : g_ch
        assign eval_out[g] = pick(pat_ff[2*g+1 -: 2], pwm_a, pwm_b);
        assign nxt_drive[g] = outen_ff[g] && run_ff[g] &&
                              (pattern_mode_bit_i[g] ? eval_out[g] : own_pwm[g]);
    end

    // Capture channel on phase input 3.
    logic bv_cap;
    logic bv_cap_last_ff;
    logic rise;
    logic fall;
    logic [23:0] cap_cnt_ff;
    logic [23:0] cap_shadow_ff;
    logic [23:0] high_ff;
    logic [23:0] period_ff;
    logic [7:0] tally_ff;

    // Duty level select low measures the low time by swapping edge roles.
    assign bv_cap = bv_sync_ff[0] ^ ~duty_level_select_i;
    assign rise = pwm_measure_mode_i && bv_cap && !bv_cap_last_ff;
    assign fall = pwm_measure_mode_i && !bv_cap && bv_cap_last_ff;

    // Counter restarts at each rising edge; rising edge wins over a coincident capture tick.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            bv_cap_last_ff <= 1'b0;
            cap_cnt_ff <= bldc_comm_pkg::CAP_RST;
            cap_shadow_ff <= bldc_comm_pkg::CAP_RST;
            high_ff <= bldc_comm_pkg::CAP_RST;
            period_ff <= bldc_comm_pkg::CAP_RST;
            tally_ff <= bldc_comm_pkg::TALLY_RST;
        end
        else
        begin
            bv_cap_last_ff <= bv_cap;
            if (rise)
            begin
                high_ff <= cap_shadow_ff;
                period_ff <= cap_cnt_ff;
                cap_cnt_ff <= bldc_comm_pkg::CAP_RST;
            end
            else if (cap_tick && pwm_measure_mode_i)
            begin
                cap_cnt_ff <= 24'(cap_cnt_ff + 24'h1);
            end
            if (fall && !shadow_source_select_i)
            begin
                cap_shadow_ff <= cap_cnt_ff;
            end
            if (rise || fall)
            begin
                tally_ff <= 8'(tally_ff + 8'h1);
            end
        end
    end

    // Registered outputs.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            gate_drive_o <= 7'h0;
            output_pattern_control_o <= bldc_comm_pkg::PAT_RST;
            new_pattern_flag_o <= 1'b0;
            delay_trigger_o <= 1'b0;
            capture_irq_o <= 1'b0;
            capture_result_o <= '0;
        end
        else
        begin
            gate_drive_o <= nxt_drive;
            output_pattern_control_o <= pat_ff;
            new_pattern_flag_o <= new_pat;
            delay_trigger_o <= hit1;
            capture_irq_o <= rise && capture_irq_enable_i;
            capture_result_o <= {high_ff, period_ff, tally_ff};
        end
    end

endmodule

// File: bldc_comm_pkg.sv
// Purpose: Shared constants and carriers for the six-step commutation timer block.
// Assumes: One 200 MHz system clock; timer rates are enable pulses made inside the block.
// Notes: Shadow values and pattern tables are supplied by software through plain ports.
package bldc_comm_pkg;

    // Clock rates in MHz; the fast timer rate is reached by a fractional accumulator.
    localparam int unsigned SYS_MHZ = 200;
    localparam int unsigned FAST_MHZ = 80;
    localparam int unsigned CAPTURE_MHZ = 1;
    localparam logic [8:0] ACC_STEP = 9'(FAST_MHZ);
    localparam logic [8:0] ACC_WRAP = 9'(SYS_MHZ);
    // Slow clock is the fast clock divided by two to the eighth.
    localparam logic [7:0] SLOW_LAST = 8'hff;
    // Capture clock divider count, derived from the two rates.
    localparam logic [7:0] CAP_LAST = 8'(SYS_MHZ / CAPTURE_MHZ - 1);

    // PWM pair period in fast timer cycles.
    localparam logic [15:0] PWM_PERIOD = 16'hfa0;
    // Start levels of the complementary pair and of the delay channel.
    localparam logic SL_CH0 = 1'b0;
    localparam logic SL_CH1 = 1'b1;
    localparam logic SL_CH2 = 1'b1;

    // Update trigger selections of the evaluator.
    localparam logic [1:0] TRIG_ON_PATTERN = 2'h0;
    localparam logic [1:0] TRIG_ON_DELAY = 2'h3;

    // Per-channel output selection codes.
    localparam logic [1:0] SEL_ZERO = 2'h0;
    localparam logic [1:0] SEL_ONE = 2'h1;
    localparam logic [1:0] SEL_SRC_A = 2'h2;
    localparam logic [1:0] SEL_SRC_B = 2'h3;

    // Reset values.
    localparam logic [15:0] CNT_RST = 16'h0;
    localparam logic [13:0] PAT_RST = 14'h0;
    localparam logic [23:0] CAP_RST = 24'h0;
    localparam logic [7:0] TALLY_RST = 8'h0;

    // Shadow pair for one output channel: second edge and first edge.
    typedef struct packed {
        logic [15:0] period_shadow;
        logic [15:0] edge_shadow;
    } pwm_shadow_s;

    // Capture results as seen by software.
    typedef struct packed {
        logic [23:0] result_high_time;
        logic [23:0] result_period;
        logic [7:0] edge_tally;
    } capture_result_s;

endpackage

// File: power_stage_model.sv
// Purpose: Stand-in for the power stage and its back voltage comparators.
// Assumes: Comparator edges fall half way between capture clock ticks.
// Notes: Only phase input 3 toggles; a tally counts phase A shoot-through.
`timescale 1ns/1ps
module power_stage_model
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Comparator timing in microseconds.
    input wire logic run_i,
    input wire logic [7:0] high_us_i,
    input wire logic [7:0] low_us_i,
    // Gate drives in; comparators and fault tally out.
    input wire logic [6:0] gate_drive_i,
    output logic [2:0] back_voltage_o,
    output logic [15:0] shoot_cnt_o
);
    logic [7:0] cyc;
    logic [7:0] us;
    // Slots of 200 cycles make a microsecond; edges land mid-slot, away from ticks.
    always @(negedge sys_clk_i)
    begin
        if (reset_i)
        begin
            cyc = 8'h0;
            us = 8'h0;
            back_voltage_o = 3'h0;
        end
        else
        begin
            cyc = (cyc == 8'hc7) ? 8'h0 : cyc + 8'h1;
            us = us + 8'((cyc == 8'h64) && run_i);
            if (us == (back_voltage_o[0] ? high_us_i : low_us_i))
            begin
                back_voltage_o[0] = ~back_voltage_o[0];
                us = 8'h0;
            end
        end
    end
    // Both gates of one leg on would short the supply.
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
            shoot_cnt_o <= 16'h0;
        else if (gate_drive_i[0] && gate_drive_i[1])
            shoot_cnt_o <= shoot_cnt_o + 16'h1;
    end
endmodule

// File: bldc_comm_chk.sv
// Purpose: Port-level timing checks of the commutation timer block.
// Assumes: One clock domain with synchronous active high reset.
// Notes: Helper flags track start, equal pair compares, rise spacing and the delayed update wait.
`timescale 1ns/1ps
module bldc_comm_chk
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Watched inputs.
    input wire logic global_trigger_i,
    input wire logic [6:0] pattern_mode_bit_i,
    input wire logic period_trigger_i,
    input wire bldc_comm_pkg::pwm_shadow_s ch0_shadow_i,
    input wire bldc_comm_pkg::pwm_shadow_s ch1_shadow_i,
    input wire bldc_comm_pkg::pwm_shadow_s ch2_shadow_i,
    input wire logic [1:0] update_trigger_select_i,
    input wire logic [13:0] next_pattern_control_i,
    input wire logic capture_irq_enable_i,
    // Watched outputs.
    input wire logic [6:0] gate_drive_o,
    input wire logic [13:0] output_pattern_control_o,
    input wire logic new_pattern_flag_o,
    input wire logic delay_trigger_o,
    input wire bldc_comm_pkg::capture_result_s capture_result_o,
    input wire logic capture_irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    logic started_ff; // Channels were started together.
    logic pair_eq_ff; // Pair compares came from equal shadows.
    logic rise_ok_ff; // No period trigger since the last rise.
    logic [13:0] rise_cyc_ff; // Cycles since the last channel 0 rise.
    logic dly_armed_ff; // A delayed pattern update is awaited.
    logic [11:0] dly_cyc_ff; // Cycles since the last new pattern flag.
    // A period trigger restarts the pair, so spacing is only judged between two free-run rises.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            started_ff <= 1'b0;
            pair_eq_ff <= 1'b0;
        end
        else
        begin
            started_ff <= started_ff | global_trigger_i;
            pair_eq_ff <= period_trigger_i ? ch0_shadow_i == ch1_shadow_i : pair_eq_ff;
        end
        // The rise just after a trigger still shows the reset compares, so it starts no span.
        if (reset_i || period_trigger_i || $past(period_trigger_i))
            rise_ok_ff <= 1'b0;
        else if ($rose(gate_drive_o[0]))
            rise_ok_ff <= started_ff;
        rise_cyc_ff <= $rose(gate_drive_o[0]) ? 14'h1 : rise_cyc_ff + 14'h1;
        // The wait is counted here because it is longer than a delay range may reach.
        if (reset_i)
            dly_armed_ff <= 1'b0;
        else if (new_pattern_flag_o && started_ff && ch2_shadow_i.edge_shadow == 16'h2 &&
            update_trigger_select_i == bldc_comm_pkg::TRIG_ON_DELAY)
            dly_armed_ff <= 1'b1;
        else if (delay_trigger_o)
            dly_armed_ff <= 1'b0;
        dly_cyc_ff <= new_pattern_flag_o ? 12'h1 : 12'(dly_cyc_ff + 12'h1);
    end
    a_pin_forced_one: assert property ((started_ff && pattern_mode_bit_i[3] &&
        output_pattern_control_o[7:6] == bldc_comm_pkg::SEL_ONE)[*3] |-> gate_drive_o[3])
        else $error("pattern one not on pin");
    a_pin_forced_zero: assert property ((started_ff && pattern_mode_bit_i[3] &&
        output_pattern_control_o[7:6] == bldc_comm_pkg::SEL_ZERO)[*3] |-> !gate_drive_o[3])
        else $error("pattern zero not on pin");
    a_pair_complement: assert property (started_ff && pair_eq_ff && $past(pair_eq_ff, 3) &&
        pattern_mode_bit_i[1:0] == 2'h0 |-> gate_drive_o[1] != gate_drive_o[0])
        else $error("pair not complementary");
    a_period_length: assert property ($rose(gate_drive_o[0]) && rise_ok_ff &&
        !pattern_mode_bit_i[0] |-> rise_cyc_ff == 14'h2710)
        else $error("pwm period wrong");
    a_delay_window: assert property (dly_armed_ff && delay_trigger_o |-> dly_cyc_ff >= 12'h258)
        else $error("delay trigger too early");
    a_delay_deadline: assert property (dly_armed_ff |-> dly_cyc_ff <= 12'h7d0)
        else $error("delay trigger too late");
    a_update_on_delay: assert property (delay_trigger_o &&
        update_trigger_select_i == bldc_comm_pkg::TRIG_ON_DELAY
        |-> ##[0:2] output_pattern_control_o == next_pattern_control_i)
        else $error("pattern not updated by delay");
    a_irq_enabled: assert property (capture_irq_o |-> $past(capture_irq_enable_i))
        else $error("request while disabled");
    a_tally_step: assert property ($changed(capture_result_o.edge_tally) && !$past(reset_i)
        |-> capture_result_o.edge_tally == $past(capture_result_o.edge_tally) + 8'h1)
        else $error("edge tally jumped");
endmodule
bind sensorless_bldc_commutation_pwm bldc_comm_chk i_chk (.sys_clk_i, .reset_i, .global_trigger_i,
    .pattern_mode_bit_i, .period_trigger_i, .ch0_shadow_i, .ch1_shadow_i, .ch2_shadow_i,
    .update_trigger_select_i, .next_pattern_control_i, .capture_irq_enable_i, .gate_drive_o,
    .output_pattern_control_o, .new_pattern_flag_o, .delay_trigger_o, .capture_result_o, .capture_irq_o);

// File: tb.sv
// Purpose: Self-checking bench of the commutation timer block.
// Assumes: Inputs change at the falling edge; capture results checked one falling edge after the request.
// Notes: Timer rates are real, so the run spans several PWM periods.
`timescale 1ns/1ps
module tb;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [6:0] channel_enable_i = 7'h0;
    logic [6:0] output_enable_i = 7'h0;
    logic global_trigger_i = 1'b0;
    logic [6:0] pattern_mode_bit_i = 7'h7c; // Pair runs on its own PWM.
    logic period_trigger_i = 1'b0;
    bldc_comm_pkg::pwm_shadow_s ch0_shadow_i = {16'hbb8, 16'h3e8}; // Centred on 2000.
    bldc_comm_pkg::pwm_shadow_s ch1_shadow_i = {16'hbb8, 16'h3e8};
    bldc_comm_pkg::pwm_shadow_s ch2_shadow_i = {16'h4, 16'h2}; // Twice and once the delay.
    logic evaluator_enable_i = 1'b0;
    logic [1:0] update_trigger_select_i = 2'h0;
    logic [13:0] next_pattern_control_i = 14'h3240;
    logic pattern_write_i = 1'b0;
    logic [2:0] back_voltage_i;
    logic [6:0] gate_drive_o;
    logic [13:0] output_pattern_control_o;
    logic new_pattern_flag_o;
    logic delay_trigger_o;
    bldc_comm_pkg::capture_result_s capture_result_o;
    logic capture_irq_o;
    logic [15:0] shoot;
    logic [7:0] hi_us;
    logic [7:0] lo_us;
    logic [7:0] last_tally;
    logic skip = 1'b1;
    logic irq_dly = 1'b0; // Request seen at the previous falling edge.
    logic capture_irq_enable_i = 1'b1;
    int spd; // Speed as software would compute it.
    logic [47:0] exp_q[$]; // Expected {high time, period} notes.
    integer seed = 32'h5e38;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc_cnt = 0;
    int n;
    always #2.5 sys_clk_i = ~sys_clk_i;
    sensorless_bldc_commutation_pwm i_dut (.sys_clk_i, .reset_i, .channel_enable_i, .output_enable_i,
        .global_trigger_i, .pattern_mode_bit_i, .one_shot_bit_i(1'b1), .period_trigger_i, .ch0_shadow_i,
        .ch1_shadow_i, .ch2_shadow_i, .evaluator_enable_i, .update_trigger_select_i, .next_pattern_control_i,
        .pattern_write_i, .back_voltage_i, .pwm_measure_mode_i(1'b1), .duty_level_select_i(1'b1),
        .shadow_source_select_i(1'b0), .capture_irq_enable_i, .gate_drive_o, .output_pattern_control_o,
        .new_pattern_flag_o, .delay_trigger_o, .capture_result_o, .capture_irq_o);
    power_stage_model i_ps (.sys_clk_i, .reset_i, .run_i(1'b1), .high_us_i(hi_us), .low_us_i(lo_us),
        .gate_drive_i(gate_drive_o), .back_voltage_o(back_voltage_i), .shoot_cnt_o(shoot));
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Counts: %0d checks, %0d mismatches", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Counts falling edges until channel 0 reaches the level; bounded.
    task automatic wait_a(input logic lvl, output int w);
        w = 0;
        do
        begin
            @(negedge sys_clk_i);
            w++;
        end
        while (gate_drive_o[0] !== lvl && w < 20000);
    endtask
    task automatic pulse_trig();
        period_trigger_i = 1'b1;
        @(negedge sys_clk_i);
        period_trigger_i = 1'b0;
    endtask
    // The first capture after start is partial, so it is passed over.
    // Results settle one cycle after the request, so they are read at the next falling edge.
    always @(negedge sys_clk_i)
    begin
        if (irq_dly)
        begin
            if (!skip)
                check(48'(capture_result_o.edge_tally - last_tally), 48'h2);
            if (!skip && exp_q.size() > 0)
                check(capture_result_o[55:8], exp_q.pop_front());
            skip = 1'b0;
            last_tally = capture_result_o.edge_tally;
        end
        irq_dly = !reset_i && capture_irq_o === 1'b1;
        // Speed is taken at a fixed interval, and never from an empty period.
        if (cyc_cnt % 10000 == 0 && exp_q.size() < 3 && capture_result_o.result_period != 24'h0)
        begin
            spd = 60000000 / (capture_result_o.result_period & 24'hffffff);
            check(48'(spd), 48'(60000000 / (hi_us + lo_us)));
        end
        cyc_cnt++;
        if (cyc_cnt == 95000)
        begin
            error_cnt++;
            give_verdict();
        end
    end
    initial
    begin
        hi_us = 8'h0b + 8'($random(seed) & 7);
        lo_us = 8'h0b + 8'($random(seed) & 7);
        repeat (3) exp_q.push_back({24'(hi_us), 24'(hi_us + lo_us)});
        repeat (6) @(negedge sys_clk_i);
        reset_i = 1'b0;
        pattern_write_i = 1'b1;
        @(negedge sys_clk_i);
        pattern_write_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        check(48'(output_pattern_control_o), 48'h3240);
        check(48'(gate_drive_o), 48'h0);
        channel_enable_i = 7'h7f;
        output_enable_i = 7'h7f;
        @(negedge sys_clk_i);
        global_trigger_i = 1'b1;
        @(negedge sys_clk_i);
        global_trigger_i = 1'b0;
        pulse_trig();
        wait_a(1'b1, n);
        wait_a(1'b0, n);
        check(48'(n), 48'd5000);
        wait_a(1'b1, n);
        check(48'(n), 48'd5000);
        $display("test pwm period done");
        ch0_shadow_i = {16'ha28, 16'h578};
        ch1_shadow_i = {16'ha28, 16'h578};
        wait_a(1'b0, n);
        check(48'(n), 48'd5000);
        wait_a(1'b1, n);
        wait_a(1'b0, n);
        check(48'(n), 48'd5000);
        pulse_trig();
        repeat (4) @(negedge sys_clk_i);
        wait_a(1'b1, n);
        wait_a(1'b0, n);
        check(48'(n), 48'd3000);
        check(48'(shoot), 48'h0);
        $display("test shadow load done");
        evaluator_enable_i = 1'b1;
        update_trigger_select_i = bldc_comm_pkg::TRIG_ON_DELAY;
        for (int k = 0; k < 4; k++)
        begin
            next_pattern_control_i = {2'h3, 2'h0, 2'h2, 2'(k), 6'h0};
            n = 0;
            while (delay_trigger_o !== 1'b1 && n < 10000)
            begin
                @(negedge sys_clk_i);
                n++;
            end
            check(48'(n < 10000), 48'h1);
            repeat (3) @(negedge sys_clk_i);
            check(48'(output_pattern_control_o), 48'(next_pattern_control_i));
            check(48'(gate_drive_o[3]), 48'((k < 2) ? 1'(k) : gate_drive_o[k - 2]));
        end
        $display("test delayed update done");
        n = 0;
        while (exp_q.size() > 0 && n < 20000)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        check(48'(exp_q.size()), 48'h0);
        $display("test capture done");
        give_verdict();
    end
endmodule
